// ---- hdl/cpbp_pkg.sv ----
// shared constants of the co-processor bus protocol
package cpbp_pkg;
  // cpu-space cycle marking and address layout
  localparam logic [2:0] CPBP_FC_CPU = 3'h7;
  localparam logic [3:0] CPBP_SPACE_CP = 4'h2;
  localparam int CPBP_AW = 20;
  localparam int CPBP_SPACE_LSB = 16;
  localparam int CPBP_ID_LSB = 13;
  // interface register locations
  localparam logic [4:0] CPBP_OFF_RESP = 5'h00;
  localparam logic [4:0] CPBP_OFF_CTRL = 5'h02;
  localparam logic [4:0] CPBP_OFF_SAVE = 5'h04;
  localparam logic [4:0] CPBP_OFF_RESTORE = 5'h06;
  localparam logic [4:0] CPBP_OFF_OPWORD = 5'h08;
  localparam logic [4:0] CPBP_OFF_CMD = 5'h0A;
  localparam logic [4:0] CPBP_OFF_COND = 5'h0E;
  localparam logic [4:0] CPBP_OFF_OPND = 5'h10;
  localparam logic [4:0] CPBP_OFF_REGSEL = 5'h14;
  localparam logic [4:0] CPBP_OFF_IADDR = 5'h18;
  localparam logic [4:0] CPBP_OFF_OADDR = 5'h1C;
  // response word fields
  localparam int CPBP_RSP_CA = 15;
  localparam int CPBP_RSP_PRIM_LSB = 8;
  localparam int CPBP_RSP_DIR = 7;
  // response primitive codes
  localparam logic [4:0] CPBP_P_BUSY = 5'h00;
  localparam logic [4:0] CPBP_P_PROCEED = 5'h01;
  localparam logic [4:0] CPBP_P_TRACE_RQ = 5'h02;
  localparam logic [4:0] CPBP_P_COND = 5'h03;
  localparam logic [4:0] CPBP_P_PRIV = 5'h04;
  localparam logic [4:0] CPBP_P_EXC_PRE = 5'h05;
  localparam logic [4:0] CPBP_P_EXC_MID = 5'h06;
  localparam logic [4:0] CPBP_P_EXC_POST = 5'h07;
  localparam logic [4:0] CPBP_P_OPWORD = 5'h08;
  localparam logic [4:0] CPBP_P_IWORDS = 5'h09;
  localparam logic [4:0] CPBP_P_EA_PASS = 5'h0A;
  localparam logic [4:0] CPBP_P_EA_XFER = 5'h0B;
  localparam logic [4:0] CPBP_P_PREV_EA = 5'h0C;
  localparam logic [4:0] CPBP_P_TAKE_ADDR = 5'h0D;
  localparam logic [4:0] CPBP_P_TOS = 5'h0E;
  localparam logic [4:0] CPBP_P_CPU_REG = 5'h0F;
  localparam logic [4:0] CPBP_P_CTRL_REG = 5'h10;
  localparam logic [4:0] CPBP_P_MULTI_CPU = 5'h11;
  localparam logic [4:0] CPBP_P_MULTI_CP = 5'h12;
  localparam logic [4:0] CPBP_P_SR_SCAN = 5'h13;
  localparam logic [15:0] CPBP_RESP_RST = 16'h0000;
  // control location bits
  localparam logic [31:0] CPBP_CTRL_XACK = 32'h0000_0002;
  localparam logic [31:0] CPBP_CTRL_ABORT = 32'h0000_0001;
  // exception kinds
  localparam logic [2:0] CPBP_EXC_PRE = 3'h0;
  localparam logic [2:0] CPBP_EXC_MID = 3'h1;
  localparam logic [2:0] CPBP_EXC_POST = 3'h2;
  localparam logic [2:0] CPBP_EXC_PRIV = 3'h3;
  localparam logic [2:0] CPBP_EXC_PROTO = 3'h4;
  // processor-side constants
  localparam int CPBP_SR_S_BIT = 13;
  localparam logic [3:0] CPBP_SP_IDX = 4'hF;
  localparam logic [31:0] CPBP_LWORD_STEP = 32'h0000_0004;
  localparam logic [31:0] CPBP_IWORD_STEP = 32'h0000_0002;
endpackage : cpbp_pkg

// ---- hdl/cpbp_bus_if.sv ----
// co-processor bus between processor end and co-processor end
interface cpbp_bus_if;
  logic [2:0] fc;
  logic as;
  logic rw;
  logic [19:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport cpu (output fc, output as, output rw, output addr, output wdata,
    input rdata, input ack);
  modport cop (input fc, input as, input rw, input addr, input wdata,
    output rdata, output ack);
endinterface : cpbp_bus_if

// ---- hdl/cpbp_cop_end.sv ----
// co-processor end: select decode and interface register set
module cpbp_cop_end import cpbp_pkg::*; #(
  parameter logic [2:0] CP_ID = 3'h0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  cpbp_bus_if.cop bus,
  input wire logic resp_load_i,
  input wire logic [15:0] resp_data_i,
  output logic resp_taken_o,
  output logic [15:0] cmd_o,
  output logic cmd_valid_o,
  output logic cmd_is_cond_o,
  output logic [15:0] opword_o,
  output logic opword_valid_o,
  output logic [15:0] ctrl_o,
  output logic ctrl_valid_o,
  input wire logic opnd_load_i,
  input wire logic [31:0] opnd_data_i,
  output logic [31:0] opnd_o,
  output logic opnd_valid_o,
  output logic opnd_taken_o,
  input wire logic regsel_load_i,
  input wire logic [15:0] regsel_data_i,
  input wire logic [15:0] save_data_i,
  output logic save_o,
  output logic restore_valid_o,
  output logic [31:0] iaddr_o,
  output logic [31:0] oaddr_o,
  output logic oaddr_valid_o,
  input wire logic oaddr_load_i,
  input wire logic [31:0] oaddr_data_i
);
  logic sel;
  logic [4:0] off;
  logic [15:0] resp, next_resp, regsel, next_regsel, restore, next_restore;
  logic [31:0] opnd, next_opnd, iaddr, next_iaddr, oaddr, next_oaddr;
  logic [15:0] next_cmd, next_opword, next_ctrl;
  logic next_cmd_valid, next_cmd_is_cond, next_opword_valid, next_ctrl_valid;
  logic next_opnd_valid, next_opnd_taken, next_resp_taken, next_save;
  logic next_restore_valid, next_oaddr_valid;

  // only our id answers; this end has no way to start a cycle of its own
  assign sel = bus.as && bus.fc == CPBP_FC_CPU &&
    bus.addr[CPBP_AW-1:CPBP_SPACE_LSB] == CPBP_SPACE_CP &&
    bus.addr[CPBP_ID_LSB+2:CPBP_ID_LSB] == CP_ID;
  assign off = bus.addr[4:0];
  assign bus.ack = sel;

  always_comb begin
    bus.rdata = 32'h0000_0000;
    if (sel && bus.rw) begin
      unique case (off)
        CPBP_OFF_RESP: bus.rdata = {16'h0000, resp};
        CPBP_OFF_SAVE: bus.rdata = {16'h0000, save_data_i};
        CPBP_OFF_RESTORE: bus.rdata = {16'h0000, restore};
        CPBP_OFF_OPND: bus.rdata = opnd;
        CPBP_OFF_REGSEL: bus.rdata = {16'h0000, regsel};
        CPBP_OFF_IADDR: bus.rdata = iaddr;
        CPBP_OFF_OADDR: bus.rdata = oaddr;
        default: bus.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_resp = resp;
    next_regsel = regsel_load_i ? regsel_data_i : regsel;
    next_restore = restore;
    next_opnd = opnd;
    next_iaddr = iaddr;
    next_oaddr = oaddr;
    next_cmd = cmd_o;
    next_cmd_is_cond = cmd_is_cond_o;
    next_opword = opword_o;
    next_ctrl = ctrl_o;
    next_cmd_valid = 1'b0;
    next_opword_valid = 1'b0;
    next_ctrl_valid = 1'b0;
    next_opnd_valid = 1'b0;
    next_opnd_taken = 1'b0;
    next_resp_taken = 1'b0;
    next_save = 1'b0;
    next_restore_valid = 1'b0;
    next_oaddr_valid = 1'b0;
    if (sel && bus.rw) begin
      // a taken answer falls back to busy until the core posts the next
      if (off == CPBP_OFF_RESP) begin
        next_resp = CPBP_RESP_RST;
        next_resp_taken = 1'b1;
      end
      next_opnd_taken = off == CPBP_OFF_OPND;
      next_save = off == CPBP_OFF_SAVE;
    end
    if (sel && !bus.rw) begin
      unique case (off)
        CPBP_OFF_CMD, CPBP_OFF_COND: begin
          next_cmd = bus.wdata[15:0];
          next_cmd_is_cond = off == CPBP_OFF_COND;
          next_cmd_valid = 1'b1;
        end
        CPBP_OFF_OPWORD: begin
          next_opword = bus.wdata[15:0];
          next_opword_valid = 1'b1;
        end
        CPBP_OFF_CTRL: begin
          next_ctrl = bus.wdata[15:0];
          next_ctrl_valid = 1'b1;
        end
        CPBP_OFF_RESTORE: begin
          next_restore = bus.wdata[15:0];
          next_restore_valid = 1'b1;
        end
        CPBP_OFF_OPND: begin
          next_opnd = bus.wdata;
          next_opnd_valid = 1'b1;
        end
        CPBP_OFF_IADDR: next_iaddr = bus.wdata;
        CPBP_OFF_OADDR: begin
          next_oaddr = bus.wdata;
          next_oaddr_valid = 1'b1;
        end
        default: next_cmd_valid = 1'b0;
      endcase
    end
    // core loads win over the bus side in the same cycle
    if (resp_load_i) next_resp = resp_data_i;
    if (opnd_load_i) next_opnd = opnd_data_i;
    if (oaddr_load_i) next_oaddr = oaddr_data_i;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp <= CPBP_RESP_RST;
      regsel <= 16'h0000;
      restore <= 16'h0000;
      opnd <= 32'h0000_0000;
      iaddr <= 32'h0000_0000;
      oaddr <= 32'h0000_0000;
      cmd_o <= 16'h0000;
      cmd_is_cond_o <= 1'b0;
      opword_o <= 16'h0000;
      ctrl_o <= 16'h0000;
      cmd_valid_o <= 1'b0;
      opword_valid_o <= 1'b0;
      ctrl_valid_o <= 1'b0;
      opnd_valid_o <= 1'b0;
      opnd_taken_o <= 1'b0;
      resp_taken_o <= 1'b0;
      save_o <= 1'b0;
      restore_valid_o <= 1'b0;
      oaddr_valid_o <= 1'b0;
    end else begin
      resp <= next_resp;
      regsel <= next_regsel;
      restore <= next_restore;
      opnd <= next_opnd;
      iaddr <= next_iaddr;
      oaddr <= next_oaddr;
      cmd_o <= next_cmd;
      cmd_is_cond_o <= next_cmd_is_cond;
      opword_o <= next_opword;
      ctrl_o <= next_ctrl;
      cmd_valid_o <= next_cmd_valid;
      opword_valid_o <= next_opword_valid;
      ctrl_valid_o <= next_ctrl_valid;
      opnd_valid_o <= next_opnd_valid;
      opnd_taken_o <= next_opnd_taken;
      resp_taken_o <= next_resp_taken;
      save_o <= next_save;
      restore_valid_o <= next_restore_valid;
      oaddr_valid_o <= next_oaddr_valid;
    end
  end

  assign opnd_o = opnd;
  assign iaddr_o = iaddr;
  assign oaddr_o = oaddr;
endmodule : cpbp_cop_end

// ---- hdl/cpbp_cpu_end.sv ----
// processor end: runs the co-processor dialogue over cpu-space cycles
// Behaviour
// - eight co-processors, picked by instruction id
// - ordinary read/write cycles, cpu-space function code
// - id on address bus, select decodes it
// - only processor starts transfers, during instruction
// - processor sends data, co-processor returns answers
// - dialogue opens with a command write
// - then read response; response directs next step
// - busy response: read response again
// - exception: acknowledge, then take exception
// - service requests done with ordinary cycles
// - come-again flag: re-read after service
// - not needed any more: end dialogue
// - both sides then run concurrently
// - operand transfers: address, data, stack top
// - register transfers: single, control, multiple
// - status register and scan pointer transfer
// - co-processor holds the interface register set
// - busy, proceed, trace re-query, condition results
// - privilege check outside supervisor state: exception
module cpbp_cpu_end import cpbp_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  cpbp_bus_if.cpu bus,
  input wire logic start_i,
  input wire logic [2:0] cp_id_i,
  input wire logic [15:0] cmd_i,
  input wire logic cond_mode_i,
  input wire logic [15:0] opword_i,
  input wire logic [15:0] iword_i,
  input wire logic [31:0] ea_i,
  input wire logic [31:0] pc_i,
  input wire logic [15:0] sr_i,
  output logic busy_o,
  output logic done_o,
  output logic cond_true_o,
  output logic exc_o,
  output logic [2:0] exc_kind_o,
  output logic trace_svc_o,
  output logic [31:0] scan_ptr_o,
  output logic [15:0] sr_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i
);
  typedef enum logic [3:0] {S_IDLE, S_CMD, S_RESP, S_EVAL, S_SEL, S_ADRD, S_UNIT,
    S_OPRD, S_OPWR, S_MEM, S_EXCACK} cpbp_state_e;
  typedef enum logic [2:0] {T_REG, T_CTRL, T_SRSP, T_MEM, T_IWORD, T_OPW, T_EA}
    cpbp_tgt_e;

  cpbp_state_e state, next_state;
  cpbp_tgt_e tgt, next_tgt;
  logic [2:0] cp_id, next_cp_id, next_exc_kind;
  logic [15:0] resp, next_resp, mask, next_mask, sr, next_sr, mask_rest;
  logic [3:0] idx, next_idx;
  logic [4:0] prim, off;
  logic [31:0] maddr, next_maddr, prev_ea, next_prev_ea, wbuf, next_wbuf;
  logic [31:0] scan, next_scan, ctrl, next_ctrl, tgt_val;
  logic [31:0] regs [16];
  logic [31:0] next_regs [16];
  logic dir, next_dir, cond_mode, next_cond_mode, ca;
  logic next_done, next_cond_true, next_exc, next_trace;

  function automatic logic [3:0] cpbp_lowest(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) r = 4'(i);
    end
    return r;
  endfunction : cpbp_lowest

  assign prim = resp[CPBP_RSP_PRIM_LSB+4:CPBP_RSP_PRIM_LSB];
  assign ca = resp[CPBP_RSP_CA];
  assign mask_rest = mask & ~(16'h0001 << idx);

  // bus cycles only while a dialogue runs
  assign bus.as = state inside {S_CMD, S_RESP, S_SEL, S_ADRD, S_OPRD, S_OPWR,
    S_EXCACK};
  assign bus.rw = state inside {S_RESP, S_SEL, S_ADRD, S_OPRD};
  assign bus.fc = CPBP_FC_CPU;
  assign bus.addr = {CPBP_SPACE_CP, cp_id, 8'h00, off};
  assign bus.wdata = wbuf;

  always_comb begin
    unique case (state)
      S_CMD: off = cond_mode ? CPBP_OFF_COND : CPBP_OFF_CMD;
      S_SEL: off = CPBP_OFF_REGSEL;
      S_ADRD: off = CPBP_OFF_OADDR;
      S_OPRD: off = CPBP_OFF_OPND;
      S_OPWR: off = tgt == T_OPW ? CPBP_OFF_OPWORD :
        (tgt == T_EA ? CPBP_OFF_OADDR : CPBP_OFF_OPND);
      S_EXCACK: off = CPBP_OFF_CTRL;
      default: off = CPBP_OFF_RESP;
    endcase
    unique case (tgt)
      T_REG: tgt_val = regs[idx];
      T_CTRL: tgt_val = ctrl;
      T_SRSP: tgt_val = idx == 4'h0 ? {16'h0000, sr} : scan;
      T_IWORD: tgt_val = {16'h0000, iword_i};
      T_OPW: tgt_val = {16'h0000, opword_i};
      T_EA: tgt_val = ea_i;
      default: tgt_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_tgt = tgt;
    next_cp_id = cp_id;
    next_resp = resp;
    next_mask = mask;
    next_idx = idx;
    next_sr = sr;
    next_maddr = maddr;
    next_prev_ea = prev_ea;
    next_wbuf = wbuf;
    next_scan = scan;
    next_ctrl = ctrl;
    next_regs = regs;
    next_dir = dir;
    next_cond_mode = cond_mode;
    next_exc_kind = exc_kind_o;
    next_cond_true = cond_true_o;
    next_done = 1'b0;
    next_exc = 1'b0;
    next_trace = 1'b0;
    unique case (state)
      S_IDLE: if (start_i) begin
        next_cp_id = cp_id_i;
        next_wbuf = {16'h0000, cmd_i};
        next_cond_mode = cond_mode_i;
        next_scan = pc_i;
        next_sr = sr_i;
        next_cond_true = 1'b0;
        next_state = S_CMD;
      end
      S_CMD: if (bus.ack) next_state = S_RESP;
      S_RESP: if (bus.ack) begin
        next_resp = bus.rdata[15:0];
        next_state = S_EVAL;
      end
      S_EVAL: begin
        next_dir = resp[CPBP_RSP_DIR];
        next_idx = resp[3:0];
        next_mask = 16'h0001 << resp[3:0];
        next_state = S_UNIT;
        unique case (prim)
          CPBP_P_BUSY: next_state = S_RESP;
          CPBP_P_PROCEED: begin
            next_state = S_IDLE;
            next_done = 1'b1;
          end
          CPBP_P_TRACE_RQ: begin
            next_trace = 1'b1;
            next_state = S_RESP;
          end
          CPBP_P_COND: begin
            next_cond_true = cond_mode & resp[0];
            next_state = S_IDLE;
            next_done = 1'b1;
          end
          CPBP_P_PRIV: if (!sr[CPBP_SR_S_BIT]) begin
            next_exc_kind = CPBP_EXC_PRIV;
            next_exc = 1'b1;
            next_state = S_IDLE;
          end else begin
            next_state = ca ? S_RESP : S_IDLE;
            next_done = !ca;
          end
          CPBP_P_EXC_PRE, CPBP_P_EXC_MID, CPBP_P_EXC_POST: begin
            next_exc_kind = prim == CPBP_P_EXC_PRE ? CPBP_EXC_PRE :
              (prim == CPBP_P_EXC_MID ? CPBP_EXC_MID : CPBP_EXC_POST);
            next_wbuf = CPBP_CTRL_XACK;
            next_state = S_EXCACK;
          end
          CPBP_P_OPWORD: begin
            next_tgt = T_OPW;
            next_dir = 1'b0;
          end
          CPBP_P_IWORDS: begin
            next_tgt = T_IWORD;
            next_dir = 1'b0;
            next_idx = 4'h0;
            next_mask = 16'hFFFF >> (4'hF - resp[3:0]);
          end
          CPBP_P_EA_PASS: begin
            next_tgt = T_EA;
            next_dir = 1'b0;
          end
          CPBP_P_EA_XFER: begin
            next_tgt = T_MEM;
            next_maddr = ea_i;
            next_prev_ea = ea_i;
          end
          CPBP_P_PREV_EA: begin
            next_tgt = T_MEM;
            next_dir = 1'b1;
            next_maddr = prev_ea;
          end
          CPBP_P_TAKE_ADDR: begin
            next_tgt = T_MEM;
            next_state = S_ADRD;
          end
          CPBP_P_TOS: begin
            next_tgt = T_MEM;
            // push pre-decrements, pop post-increments the stack pointer
            if (resp[CPBP_RSP_DIR]) begin
              next_maddr = regs[CPBP_SP_IDX] - CPBP_LWORD_STEP;
              next_regs[CPBP_SP_IDX] = regs[CPBP_SP_IDX] - CPBP_LWORD_STEP;
            end else begin
              next_maddr = regs[CPBP_SP_IDX];
              next_regs[CPBP_SP_IDX] = regs[CPBP_SP_IDX] + CPBP_LWORD_STEP;
            end
          end
          CPBP_P_CPU_REG: next_tgt = T_REG;
          CPBP_P_CTRL_REG: next_tgt = T_CTRL;
          CPBP_P_MULTI_CPU: begin
            next_tgt = T_REG;
            next_state = S_SEL;
          end
          CPBP_P_MULTI_CP: begin
            next_tgt = T_MEM;
            next_maddr = ea_i;
            next_state = S_SEL;
          end
          CPBP_P_SR_SCAN: begin
            next_tgt = T_SRSP;
            next_mask = {14'h0000, resp[1:0]};
            next_idx = resp[0] ? 4'h0 : 4'h1;
            if (resp[1:0] == 2'b00) begin
              next_state = ca ? S_RESP : S_IDLE;
              next_done = !ca;
            end
          end
          default: begin
            // unknown answer: abort the co-processor, raise protocol fault
            next_exc_kind = CPBP_EXC_PROTO;
            next_wbuf = CPBP_CTRL_ABORT;
            next_state = S_EXCACK;
          end
        endcase
      end
      S_SEL: if (bus.ack) begin
        next_mask = bus.rdata[15:0];
        next_idx = cpbp_lowest(bus.rdata[15:0]);
        if (bus.rdata[15:0] == 16'h0000) begin
          next_state = ca ? S_RESP : S_IDLE;
          next_done = !ca;
        end else begin
          next_state = S_UNIT;
        end
      end
      S_ADRD: if (bus.ack) begin
        next_maddr = bus.rdata;
        next_prev_ea = bus.rdata;
        next_state = S_UNIT;
      end
      S_UNIT: begin
        if (dir) next_state = S_OPRD;
        else if (tgt == T_MEM) next_state = S_MEM;
        else begin
          next_wbuf = tgt_val;
          next_state = S_OPWR;
        end
        if (tgt == T_IWORD) next_scan = scan + CPBP_IWORD_STEP;
      end
      S_OPRD, S_OPWR, S_MEM: begin
        if (state == S_OPRD && bus.ack && tgt == T_MEM) begin
          next_wbuf = bus.rdata;
          next_state = S_MEM;
        end else if (state == S_MEM && mem_ack_i && !dir) begin
          next_wbuf = mem_rdata_i;
          next_state = S_OPWR;
        end else if ((state == S_MEM && mem_ack_i) || (state != S_MEM && bus.ack)) begin
          if (state == S_OPRD) begin
            unique case (tgt)
              T_REG: next_regs[idx] = bus.rdata;
              T_CTRL: next_ctrl = bus.rdata;
              default: if (idx == 4'h0) next_sr = bus.rdata[15:0];
                else next_scan = bus.rdata;
            endcase
          end
          // step to the next selected unit or close the service
          if (mask_rest == 16'h0000) begin
            next_state = ca ? S_RESP : S_IDLE;
            next_done = !ca;
          end else begin
            next_idx = cpbp_lowest(mask_rest);
            next_maddr = maddr + CPBP_LWORD_STEP;
            next_state = S_UNIT;
          end
          next_mask = mask_rest;
        end
      end
      S_EXCACK: if (bus.ack) begin
        next_exc = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= S_IDLE;
      tgt <= T_REG;
      cp_id <= 3'h0;
      resp <= CPBP_RESP_RST;
      mask <= 16'h0000;
      idx <= 4'h0;
      sr <= 16'h0000;
      maddr <= 32'h0000_0000;
      prev_ea <= 32'h0000_0000;
      wbuf <= 32'h0000_0000;
      scan <= 32'h0000_0000;
      ctrl <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) regs[i] <= 32'h0000_0000;
      dir <= 1'b0;
      cond_mode <= 1'b0;
      exc_kind_o <= CPBP_EXC_PRE;
      cond_true_o <= 1'b0;
      done_o <= 1'b0;
      exc_o <= 1'b0;
      trace_svc_o <= 1'b0;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      cp_id <= next_cp_id;
      resp <= next_resp;
      mask <= next_mask;
      idx <= next_idx;
      sr <= next_sr;
      maddr <= next_maddr;
      prev_ea <= next_prev_ea;
      wbuf <= next_wbuf;
      scan <= next_scan;
      ctrl <= next_ctrl;
      regs <= next_regs;
      dir <= next_dir;
      cond_mode <= next_cond_mode;
      exc_kind_o <= next_exc_kind;
      cond_true_o <= next_cond_true;
      done_o <= next_done;
      exc_o <= next_exc;
      trace_svc_o <= next_trace;
    end
  end

  assign busy_o = state != S_IDLE;
  assign mem_req_o = state == S_MEM;
  assign mem_we_o = dir;
  assign mem_addr_o = maddr;
  assign mem_wdata_o = wbuf;
  assign scan_ptr_o = scan;
  assign sr_o = sr;
endmodule : cpbp_cpu_end

// ---- tb/cpbp_bus_sva.sv ----
// protocol checker on the co-processor bus
module cpbp_bus_sva import cpbp_pkg::*; #(
  parameter logic [2:0] CP_ID = 3'h0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] fc,
  input wire logic as,
  input wire logic rw,
  input wire logic [19:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic rsp;
  assign rsp = as && ack && rw && addr[4:0] == CPBP_OFF_RESP;
  property p_fc; as |-> fc == CPBP_FC_CPU; endproperty
  a_fc: assert property (p_fc) else $error("cycle outside cpu space");
  property p_map; as |-> addr[19:16] == CPBP_SPACE_CP && addr[12:5] == 8'h00; endproperty
  a_map: assert property (p_map) else $error("bad address layout");
  property p_sel; as |-> ack == (addr[15:13] == CP_ID); endproperty
  a_sel: assert property (p_sel) else $error("select decode wrong");
  property p_init; ack |-> as; endproperty
  a_init: assert property (p_init) else $error("answer without request");
  property p_quiet; !(as && rw) |-> rdata == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside read");
  property p_cmd; as && !rw && (addr[4:0] == CPBP_OFF_CMD || addr[4:0] == CPBP_OFF_COND)
    |=> rsp; endproperty
  a_cmd: assert property (p_cmd) else $error("no response read after command");
  property p_busy; rsp && rdata[12:8] == CPBP_P_BUSY |-> ##[1:3] rsp; endproperty
  a_busy: assert property (p_busy) else $error("busy not queried again");
  property p_exc; rsp && rdata[12:8] >= CPBP_P_EXC_PRE && rdata[12:8] <= CPBP_P_EXC_POST
    |-> ##[1:3] as && !rw && addr[4:0] == CPBP_OFF_CTRL && wdata == CPBP_CTRL_XACK; endproperty
  a_exc: assert property (p_exc) else $error("exception not acknowledged");
  property p_end; rsp && rdata[12:8] == CPBP_P_PROCEED && !rdata[15] |=> !as [*2]; endproperty
  a_end: assert property (p_end) else $error("bus used after dialogue end");
endmodule : cpbp_bus_sva

// ---- tb/tb_top.sv ----
// bench: processor end facing co-processor end
module tb_top import cpbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] TBL [11] = '{16'h0100, 16'h0301, 16'h0300, 16'h0400,
    16'h0500, 16'h0600, 16'h0700, 16'h0F03, 16'h0B00, 16'h0A00, 16'h1302};
  logic clk_i = 0, nrst_i = 0, start_i = 0, cond_mode_i = 0, resp_load_i = 0;
  logic [15:0] cmd_i = 0, sr_i = 0, resp_data_i = 0, cmd_o, ctrl_o, sr_o;
  logic [31:0] rnd = 0, opnd_o, oaddr_o;
  logic done_o, exc_o, cond_true_o, cmd_is_cond_o, busy_o, mem_ack = 1;
  logic [2:0] exc_kind_o, cp_id = 3'h5;
  int fails = 0, compares = 0, rsp_reads = 0;
  cpbp_bus_if i_cpbp_bus_if ();
  cpbp_cpu_end i_cpbp_cpu_end (.clk_i(clk_i), .nrst_i(nrst_i), .bus(i_cpbp_bus_if),
    .start_i(start_i), .cp_id_i(cp_id), .cmd_i(cmd_i), .cond_mode_i(cond_mode_i),
    .opword_i(rnd[15:0]), .iword_i(rnd[31:16]), .ea_i(rnd), .pc_i(rnd), .sr_i(sr_i),
    .busy_o(busy_o), .done_o(done_o), .cond_true_o(cond_true_o), .exc_o(exc_o),
    .exc_kind_o(exc_kind_o), .trace_svc_o(), .scan_ptr_o(), .sr_o(sr_o), .mem_req_o(),
    .mem_we_o(), .mem_addr_o(), .mem_wdata_o(), .mem_rdata_i(rnd), .mem_ack_i(mem_ack));
  cpbp_cop_end #(.CP_ID(3'h5)) i_cpbp_cop_end (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus(i_cpbp_bus_if), .resp_load_i(resp_load_i), .resp_data_i(resp_data_i),
    .resp_taken_o(), .cmd_o(cmd_o), .cmd_valid_o(), .cmd_is_cond_o(cmd_is_cond_o),
    .opword_o(), .opword_valid_o(), .ctrl_o(ctrl_o), .ctrl_valid_o(), .opnd_load_i(1'b0),
    .opnd_data_i(rnd), .opnd_o(opnd_o), .opnd_valid_o(), .opnd_taken_o(), .regsel_load_i(1'b0),
    .regsel_data_i(rnd[15:0]), .save_data_i(rnd[15:0]), .save_o(), .restore_valid_o(),
    .iaddr_o(), .oaddr_o(oaddr_o), .oaddr_valid_o(), .oaddr_load_i(1'b0), .oaddr_data_i(rnd));
  cpbp_bus_sva #(.CP_ID(3'h5)) i_cpbp_bus_sva (.clk_i(clk_i), .nrst_i(nrst_i),
    .fc(i_cpbp_bus_if.fc), .as(i_cpbp_bus_if.as), .rw(i_cpbp_bus_if.rw),
    .addr(i_cpbp_bus_if.addr), .wdata(i_cpbp_bus_if.wdata), .rdata(i_cpbp_bus_if.rdata),
    .ack(i_cpbp_bus_if.ack));
  initial forever #2 clk_i = ~clk_i;
  // memory answers late at random to stretch the service wait
  always @(posedge clk_i) #1 mem_ack = 1'($urandom);
  always @(posedge clk_i) begin
    if (i_cpbp_bus_if.as && i_cpbp_bus_if.ack && i_cpbp_bus_if.rw
        && i_cpbp_bus_if.addr[4:0] == CPBP_OFF_RESP) rsp_reads++;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // exception flag and kind a response should lead to
  function automatic logic [3:0] exp_out(input logic [15:0] rsp, input logic [15:0] sr);
    if (rsp[12:8] >= CPBP_P_EXC_PRE && rsp[12:8] <= CPBP_P_EXC_POST)
      return {1'b1, 3'(rsp[12:8] - CPBP_P_EXC_PRE)};
    if (rsp[12:8] == CPBP_P_PRIV && !sr[CPBP_SR_S_BIT]) return {1'b1, CPBP_EXC_PRIV};
    return 4'h0;
  endfunction : exp_out
  // late response load leaves the first reads busy
  task run(input logic [15:0] rsp, input logic cm, input int d);
    int n;
    logic [3:0] e;
    logic dn, ex;
    @(posedge clk_i);
    #1 cmd_i = 16'($urandom);
    sr_i = 16'($urandom);
    cond_mode_i = cm;
    start_i = 1;
    rsp_reads = 0;
    resp_data_i = rsp;
    resp_load_i = (d == 0);
    @(posedge clk_i);
    #1 start_i = 0;
    resp_load_i = 0;
    if (d > 0) begin
      repeat (d) @(posedge clk_i);
      #1 resp_load_i = 1;
      @(posedge clk_i);
      #1 resp_load_i = 0;
    end
    n = 0;
    dn = 0;
    ex = 0;
    while (!(dn || ex) && n < 60) begin
      @(posedge clk_i);
      #1 dn = (done_o === 1'b1);
      ex = (exc_o === 1'b1);
      n++;
    end
    e = exp_out(rsp, sr_i);
    check(ex, e[3]);
    check(dn, !e[3]);
    check(busy_o, 0);
    check(sr_o, sr_i);
    if (e[3]) check(exc_kind_o, e[2:0]);
    if (e[3] && rsp[12:8] != CPBP_P_PRIV) check(ctrl_o, CPBP_CTRL_XACK[15:0]);
    check(cond_true_o, cm && rsp[12:8] == CPBP_P_COND && rsp[0]);
    check(cmd_o, cmd_i);
    check(cmd_is_cond_o, cm);
    if (rsp[12:8] == CPBP_P_EA_XFER) check(opnd_o, rnd);
    if (rsp[12:8] == CPBP_P_SR_SCAN) check(opnd_o, rnd);
    if (rsp[12:8] == CPBP_P_EA_PASS) check(oaddr_o, rnd);
    if (d > 4) check(rsp_reads > 1, 1);
  endtask : run
  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    // long enough for all dialogues with margin
    #40000;
    fails++;
    test_done;
  end
  initial begin
    void'($urandom(32'h0548));
    repeat (10) @(posedge clk_i);
    #1 nrst_i = 1;
    for (int i = 0; i < 11; i++) run(TBL[i], 1'(i), 0);
    run(16'h0100, 1'b0, 8);
    // second reset between dialogues, with both ends idle
    @(posedge clk_i);
    #1 nrst_i = 0;
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1;
    for (int i = 0; i < 24; i++) begin
      rnd = $urandom;
      run(TBL[$urandom % 11], 1'($urandom), $urandom % 8);
    end
    test_done;
  end
endmodule : tb_top
